// [tb/clk_src_model.sv]
`timescale 1ns/1ps
`default_nettype none
module clk_src_model
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_reset_n,
    output logic [6:0]      o_src_clk,
    output logic [7:0]      o_route_clk
);
    logic [7:0] cnt_q;
    // ==========================================
    // Free running sources, except source 1 which is held low
    // Period 80 keeps source 0 at exactly 10 cycles
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            cnt_q <= 8'h00;
        else
            cnt_q <= (cnt_q == 8'h4F) ? 8'h00 : cnt_q + 8'h01;
    end
    assign o_src_clk = {cnt_q[6:2], 1'b0, (cnt_q % 8'h0A) >= 8'h05};
    assign o_route_clk = {8{cnt_q[3]}};
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import clk_ctrl_pkg::*;
    logic         i_sys_clk, i_reset_n, i_mode_req_valid, o_slow_clk_en;
    logic         i_watch_low_power, i_usb_use_doubler, seen1;
    logic         o_watch_low_power, o_usb_use_doubler, o_cpu_tick, o_bus_tick;
    logic [6:0]   i_src_clk, i_src_avail;
    logic [7:0]   i_route_clk, i_dig_chain, i_active_tmpl, i_alt_tmpl;
    logic [7:0]   o_dig_tick, o_subsys_en;
    logic [15:0]  i_bus_ratio, i_ana_skew;
    logic [23:0]  i_dig_sel;
    logic [127:0] i_dig_ratio;
    logic [11:0]  i_ana_sel;
    logic [3:0]   o_ana_tick;
    logic [63:0]  i_ana_ratio;
    logic [5:0]   i_wake;
    logic [1:0]   i_reg_disable, o_core_reg_en;
    logic [2:0]   o_sys_src;
    pm_t          i_mode_req, o_power_mode;
    int           error_cnt, cmp_count, n, na, nb, nc;
    clock_tree_and_power_modes clock_tree_and_power_modes_i
    (
        .i_sys_clk, .i_reset_n, .i_src_clk, .i_src_avail, .i_route_clk,
        .i_bus_ratio, .i_dig_sel, .i_dig_ratio, .i_dig_chain, .i_ana_sel,
        .i_ana_ratio, .i_ana_skew, .i_watch_low_power, .i_usb_use_doubler,
        .i_mode_req_valid, .i_mode_req, .i_active_tmpl, .i_alt_tmpl,
        .i_wake, .i_reg_disable, .o_sys_src, .o_bus_clk(), .o_bus_tick,
        .o_cpu_tick, .o_dig_clk(), .o_dig_tick, .o_ana_clk(),
        .o_ana_tick, .o_sleep_tick(), .o_rtc_second(), .o_watch_low_power,
        .o_usb_use_doubler, .o_power_mode, .o_subsys_en, .o_slow_clk_en,
        .o_core_reg_en
    );
    clk_src_model clk_src_model_i
    (
        .i_sys_clk, .i_reset_n, .o_src_clk(i_src_clk),
        .o_route_clk(i_route_clk)
    );
    always #2 i_sys_clk = ~i_sys_clk;
    // ==========================================
    // Compare and verdict
    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (e !== g)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic req(input pm_t m);
        @(posedge i_sys_clk);
        i_mode_req_valid <= 1'b1;
        i_mode_req <= m;
        @(posedge i_sys_clk);
        i_mode_req_valid <= 1'b0;
    endtask
    // Bounded poll; a stuck mode ends the run
    task automatic wait_mode(input pm_t m);
        n = 0;
        while (o_power_mode !== m && n < 20)
        begin
            @(negedge i_sys_clk);
            n++;
        end
        chk("power_mode", 32'(m), 32'(o_power_mode));
        @(posedge i_sys_clk);
        if (n == 20)
            give_verdict();
    endtask
    // ==========================================
    // Scenarios
    task automatic t_modes();
        req(PM_ALTERNATE);
        wait_mode(PM_ALTERNATE);
        chk("alt_en", 32'(i_alt_tmpl), 32'(o_subsys_en));
        for (int i = 0; i < 6; i++)
        begin
            req(PM_SLEEP);
            wait_mode(PM_SLEEP);
            chk("sleep", 32'h1, 32'({o_subsys_en, o_slow_clk_en}));
            @(posedge i_sys_clk);
            i_wake <= 6'h01 << i;
            wait_mode(PM_ACTIVE);
            chk("cpu_on", 32'h1, 32'(o_subsys_en[0]));
            i_wake <= 6'h00;
            repeat (4) @(posedge i_sys_clk);
        end
        req(PM_HIBERNATE);
        req(PM_ACTIVE);
        wait_mode(PM_HIBERNATE);
        i_wake <= 6'h3D;
        repeat (10) @(negedge i_sys_clk);
        chk("hib", 32'h6, 32'({o_power_mode, o_slow_clk_en}));
        @(posedge i_sys_clk);
        i_wake <= 6'h02;
        wait_mode(PM_ACTIVE);
        i_wake <= 6'h00;
    endtask
    task automatic t_div();
        n = 0;
        seen1 = 1'b0;
        {na, nb, nc} = '0;
        while (o_dig_tick[0] !== 1'b1 && n < 300)
        begin
            @(negedge i_sys_clk);
            n++;
        end
        n = 0;
        do
        begin
            @(negedge i_sys_clk);
            n++;
            seen1 = seen1 | o_dig_tick[1];
            na += o_ana_tick[0];
            nb += o_bus_tick;
            nc += o_cpu_tick;
        end
        while (o_dig_tick[0] !== 1'b1 && n < 300);
        chk("div4_period", 32'd40, 32'(n));
        chk("div1_held", 32'h0, 32'(seen1));
        chk("ana_ticks", 32'd2, 32'(na));
        chk("bus_running", 32'h1, 32'(nb > 0));
        chk("cpu_ticks", 32'(nb), 32'(nc));
    endtask
    initial
    begin
        {i_sys_clk, i_reset_n, i_mode_req_valid, i_wake} = '0;
        {i_watch_low_power, i_usb_use_doubler, i_reg_disable} = '0;
        {i_dig_chain, i_dig_sel, i_ana_sel, i_ana_skew} = '0;
        i_mode_req = PM_ACTIVE;
        i_src_avail = 7'h7F;
        {i_active_tmpl, i_alt_tmpl} = 16'hA45A;
        i_bus_ratio = 16'h0002;
        i_dig_ratio = {96'h0, 32'h0001_0004};
        i_ana_ratio = {4{16'h0002}};
        error_cnt = 0;
        cmp_count = 0;
        repeat (20) @(posedge i_sys_clk);
        chk("rst_mode", 32'h7,
            32'({o_power_mode, o_core_reg_en, o_slow_clk_en}));
        i_reset_n <= 1'b1;
        repeat (10) @(negedge i_sys_clk);
        chk("tmpl", 32'h00A4, 32'(o_subsys_en));
        chk("fastest", 32'(SRC_PLL), 32'(o_sys_src));
        t_modes();
        t_div();
        @(posedge i_sys_clk);
        i_src_avail <= 7'h61;
        i_reg_disable <= 2'b01;
        {i_watch_low_power, i_usb_use_doubler} <= 2'b11;
        @(posedge i_sys_clk);
        i_reg_disable <= 2'b00;
        repeat (10) @(negedge i_sys_clk);
        chk("reg_en", 32'h2, 32'(o_core_reg_en));
        chk("fallback", 32'(SRC_MAIN_OSC), 32'(o_sys_src));
        chk("opts", 32'h3, 32'({o_watch_low_power, o_usb_use_doubler}));
        give_verdict();
    end
endmodule
`default_nettype wire

// [verilog/clk_ctrl_pkg.sv]
// Function
// R01: All seven clock sources feed distribution
// R02: System clock picks fastest available source
// R03: Bus clock divides system clock; CPU follows
// R04: Eight 16-bit digital dividers, any source
// R05: Four analog dividers with adjustable skew
// R06: Eight-way select, divide two up, ~50% duty
// R07: Outputs resynchronised and deglitched to system
// R08: Digital divider chains through interconnect input
// R09: Eight interconnect clocks feed digital dividers
// R10: Interconnect carries pin or logic clocks
// R11: Watch crystal feeds sleep timer, 1 s tick
// R12: Watch oscillator has two power settings
// R13: USB uses 48 MHz route or doubler
// R14: USB domain asynchronous, bridged by bus
// R15: Four power modes, active down to hibernate
// R16: Active mode enables per its template
// R17: Alternate active uses its own template
// R18: Sleep disables all but slow clocks
// R19: Sleep exits only on listed wake events
// R20: Hibernate stops clocks, pin wake only
// R21: Core regulators start on, software disables
// R22: Wakeup returns active and forces CPU on
// R23: Active mode after reset
// R24: Config changes only at output boundary; skew and chaining take effect at once
// R25: Ratio zero or one holds output low
package clk_ctrl_pkg;

    localparam int NUM_SRC  = 7;
    localparam int NUM_DIG  = 8;
    localparam int NUM_ANA  = 4;
    localparam int NUM_SUB  = 8;
    localparam int NUM_WAKE = 6;
    localparam int DIV_W    = 16;
    localparam int SEL_W    = 3;
    localparam int SKEW_W   = 4;
    localparam int DLY_LEN  = 16;

    // Source indices on the seven-wide source bus; SEL_ROUTE_IN selects the divider's eighth input
    localparam logic [SEL_W-1:0] SRC_MAIN_OSC  = 3'h0;
    localparam logic [SEL_W-1:0] SRC_HF_XTAL   = 3'h1;
    localparam logic [SEL_W-1:0] SRC_ROUTE     = 3'h2;
    localparam logic [SEL_W-1:0] SRC_PLL       = 3'h3;
    localparam logic [SEL_W-1:0] SRC_DOUBLER   = 3'h4;
    localparam logic [SEL_W-1:0] SRC_LOW_OSC   = 3'h5;
    localparam logic [SEL_W-1:0] SRC_WATCH     = 3'h6;
    localparam logic [SEL_W-1:0] SEL_ROUTE_IN  = 3'h7;

    // Wake input positions
    localparam int WAKE_CMP   = 0;
    localparam int WAKE_PIN   = 1;
    localparam int WAKE_I2C   = 2;
    localparam int WAKE_RTC   = 3;
    localparam int WAKE_TICK  = 4;
    localparam int WAKE_UNDERV = 5;

    localparam int SUB_CPU = 0;

    localparam logic [DIV_W-1:0] RATIO_MIN   = 16'h0002;
    localparam logic [DIV_W-1:0] DIV_RST     = 16'h0000;
    localparam logic [SEL_W-1:0] SEL_RST     = 3'h0;
    localparam logic [1:0]       REG_EN_RST  = 2'h3;
    localparam logic [14:0]      WATCH_PER_S = 15'h7FFF;

    // R15 four power modes
    typedef enum logic [1:0]
    {
        PM_ACTIVE    = 2'b00,
        PM_ALTERNATE = 2'b01,
        PM_SLEEP     = 2'b10,
        PM_HIBERNATE = 2'b11
    } pm_t;

endpackage

// [verilog/clk_divider.sv]
`timescale 1ns/1ps
`default_nettype none
module clk_divider
(
    input  wire logic                                i_sys_clk,
    input  wire logic                                i_reset_n,
    input  wire logic [7:0]                          i_src,
    input  wire logic [clk_ctrl_pkg::SEL_W-1:0]      i_sel,
    input  wire logic [clk_ctrl_pkg::DIV_W-1:0]      i_ratio,
    input  wire logic [clk_ctrl_pkg::SKEW_W-1:0]     i_skew,
    input  wire logic                                i_run,
    output logic                                     o_clk,
    output logic                                     o_tick
);
    import clk_ctrl_pkg::*;

    logic [7:0]       prev_q;
    logic [SEL_W-1:0] sel_q;
    logic [DIV_W-1:0] ratio_q;
    logic [DIV_W-1:0] count_q;
    logic             raw_q;
    logic [DLY_LEN-1:0] dly_q;
    logic             edge_hit;
    logic             wrap;
    logic             ratio_ok;
    logic [DIV_W-1:0] high_len;
    logic             clk_next;

    // =======================================================
    // Source edge detection
    // =======================================================
    // R06 eight-way select
    assign edge_hit = i_src[sel_q] & ~prev_q[sel_q];
    assign ratio_ok = (ratio_q >= RATIO_MIN);
    assign wrap     = edge_hit && (count_q == ratio_q - 16'h0001);
    assign high_len = ratio_q - (ratio_q >> 1);

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            prev_q <= 8'h00;
        else
            prev_q <= i_src;
    end

    // =======================================================
    // Configuration reload and counter
    // =======================================================
    // R24 reload at wrap, or every cycle while stopped or ratio below two
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            sel_q   <= SEL_RST;
            ratio_q <= DIV_RST;
        end
        else if (!i_run || !ratio_ok || wrap)
        begin
            sel_q   <= i_sel;
            ratio_q <= i_ratio;
        end
    end

    // R06 divide with ~50% duty
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            count_q <= DIV_RST;
            raw_q   <= 1'b0;
        end
        else if (!i_run || !ratio_ok)
        begin
            count_q <= DIV_RST;
            // R25 stalled divider holds low
            raw_q   <= 1'b0;
        end
        else if (edge_hit)
        begin
            // R07 changes only on a source edge, no runts
            count_q <= wrap ? DIV_RST : count_q + 16'h0001;
            // Rises only at wrap, so a restart never opens with a runt
            raw_q   <= wrap | (raw_q & (count_q + 16'h0001 < high_len));
        end
    end

    // =======================================================
    // Skew delay and registered outputs
    // =======================================================
    // R05 skew delays the edge in system cycles
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            dly_q <= '0;
        else
            dly_q <= {dly_q[DLY_LEN-2:0], raw_q};
    end

    assign clk_next = (i_skew == '0) ? raw_q : dly_q[i_skew - 4'h1];

    // R07 resynchronised output flop
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_clk  <= 1'b0;
            o_tick <= 1'b0;
        end
        else
        begin
            o_clk  <= clk_next;
            o_tick <= clk_next & ~o_clk;
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);

    sequence low_ratio_s;
        !ratio_ok && i_run;
    endsequence

    low_ratio_hold_a: assert property (low_ratio_s |=> !raw_q) // R25
        else $error("divider with ratio below two drove high");
    edge_only_a: assert property ($changed(raw_q) && $past(i_run)
                                   && $past(ratio_ok) |-> $past(edge_hit)) // R07
        else $error("divider output moved without a source edge");
    reload_bound_a: assert property ($changed(ratio_q) && $past(i_run)
                                   && $past(ratio_ok) |-> $past(wrap)) // R24
        else $error("ratio reloaded away from output boundary");
    rise_at_wrap_a: assert property ($rose(raw_q) |-> $past(wrap)) // R06
        else $error("divider output rose away from the wrap point");
endmodule
`default_nettype wire

// [verilog/clock_tree_and_power_modes.sv]
`timescale 1ns/1ps
`default_nettype none
module clock_tree_and_power_modes
(
    input  wire logic                                    i_sys_clk,
    input  wire logic                                    i_reset_n,
    input  wire logic [clk_ctrl_pkg::NUM_SRC-1:0]        i_src_clk,
    input  wire logic [clk_ctrl_pkg::NUM_SRC-1:0]        i_src_avail,
    input  wire logic [clk_ctrl_pkg::NUM_DIG-1:0]        i_route_clk,
    input  wire logic [clk_ctrl_pkg::DIV_W-1:0]          i_bus_ratio,
    input  wire logic [clk_ctrl_pkg::NUM_DIG*3-1:0]      i_dig_sel,
    input  wire logic [clk_ctrl_pkg::NUM_DIG*16-1:0]     i_dig_ratio,
    input  wire logic [clk_ctrl_pkg::NUM_DIG-1:0]        i_dig_chain,
    input  wire logic [clk_ctrl_pkg::NUM_ANA*3-1:0]      i_ana_sel,
    input  wire logic [clk_ctrl_pkg::NUM_ANA*16-1:0]     i_ana_ratio,
    input  wire logic [clk_ctrl_pkg::NUM_ANA*4-1:0]      i_ana_skew,
    input  wire logic                                    i_watch_low_power,
    input  wire logic                                    i_usb_use_doubler,
    input  wire logic                                    i_mode_req_valid,
    input  wire clk_ctrl_pkg::pm_t                       i_mode_req,
    input  wire logic [clk_ctrl_pkg::NUM_SUB-1:0]        i_active_tmpl,
    input  wire logic [clk_ctrl_pkg::NUM_SUB-1:0]        i_alt_tmpl,
    input  wire logic [clk_ctrl_pkg::NUM_WAKE-1:0]       i_wake,
    input  wire logic [1:0]                              i_reg_disable,
    output logic [clk_ctrl_pkg::SEL_W-1:0]               o_sys_src,
    output logic                                         o_bus_clk,
    output logic                                         o_bus_tick,
    output logic                                         o_cpu_tick,
    output logic [clk_ctrl_pkg::NUM_DIG-1:0]             o_dig_clk,
    output logic [clk_ctrl_pkg::NUM_DIG-1:0]             o_dig_tick,
    output logic [clk_ctrl_pkg::NUM_ANA-1:0]             o_ana_clk,
    output logic [clk_ctrl_pkg::NUM_ANA-1:0]             o_ana_tick,
    output logic                                         o_sleep_tick,
    output logic                                         o_rtc_second,
    output logic                                         o_watch_low_power,
    output logic                                         o_usb_use_doubler,
    output clk_ctrl_pkg::pm_t                            o_power_mode,
    output logic [clk_ctrl_pkg::NUM_SUB-1:0]             o_subsys_en,
    output logic                                         o_slow_clk_en,
    output logic [1:0]                                   o_core_reg_en
);
    import clk_ctrl_pkg::*;

    // =======================================================
    // Input synchronisers
    // =======================================================
    localparam int SYNC_W = NUM_SRC + NUM_DIG + NUM_WAKE;

    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] sync_q;
    logic [NUM_SRC-1:0]  src_s;
    logic [NUM_DIG-1:0]  route_s;
    logic [NUM_WAKE-1:0] wake_s;

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            // R10 pin and logic clocks enter through here
            meta_q <= {i_wake, i_route_clk, i_src_clk};
            sync_q <= meta_q;
        end
    end

    assign src_s   = sync_q[NUM_SRC-1:0];
    assign route_s = sync_q[NUM_SRC+NUM_DIG-1:NUM_SRC];
    assign wake_s  = sync_q[SYNC_W-1:NUM_SRC+NUM_DIG];

    // =======================================================
    // Power mode sequencer
    // =======================================================
    pm_t  mode_q;
    pm_t  mode_d;
    logic cpu_force_q;
    logic wake_any;
    logic clocks_run;

    always_comb
    begin
        wake_any = 1'b0;
        case (mode_q)
            // R19 only the listed sources end sleep
            PM_SLEEP:     wake_any = |wake_s;
            // R20 hibernate wakes on pin events alone
            PM_HIBERNATE: wake_any = wake_s[WAKE_PIN];
            default:      wake_any = 1'b0;
        endcase
    end

    always_comb
    begin
        mode_d = mode_q;
        case (mode_q)
            PM_ACTIVE, PM_ALTERNATE:
            begin
                if (i_mode_req_valid)
                    mode_d = i_mode_req;
            end
            PM_SLEEP, PM_HIBERNATE:
            begin
                // R22 any wake returns to active
                if (wake_any)
                    mode_d = PM_ACTIVE;
            end
            default: mode_d = PM_ACTIVE;
        endcase
    end

    // R23 reset lands in active mode
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            mode_q <= PM_ACTIVE;
        else
            mode_q <= mode_d;
    end

    // R22 forced CPU on; wake wins over a same-cycle request
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            cpu_force_q <= 1'b0;
        else if (wake_any)
            cpu_force_q <= 1'b1;
        else if (i_mode_req_valid)
            cpu_force_q <= 1'b0;
    end

    assign clocks_run = (mode_q == PM_ACTIVE) || (mode_q == PM_ALTERNATE);

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_power_mode  <= PM_ACTIVE;
            o_subsys_en   <= '0;
            o_slow_clk_en <= 1'b1;
        end
        else
        begin
            o_power_mode <= mode_q;
            case (mode_q)
                // R16 per-subsystem enable from active template
                PM_ACTIVE:    o_subsys_en <= i_active_tmpl;
                // R17 alternate active has its own template
                PM_ALTERNATE: o_subsys_en <= i_alt_tmpl;
                // R18 sleep ignores the templates
                default:      o_subsys_en <= '0;
            endcase
            if (cpu_force_q && clocks_run)
                o_subsys_en[SUB_CPU] <= 1'b1;
            // R18 slow clocks survive sleep, R20 not hibernate
            o_slow_clk_en <= (mode_q != PM_HIBERNATE);
        end
    end

    // =======================================================
    // Core regulators
    // =======================================================
    // R21 regulators on after power-up, software turns off
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_core_reg_en <= REG_EN_RST;
        else
            o_core_reg_en <= o_core_reg_en & ~i_reg_disable;
    end

    // =======================================================
    // System clock selection
    // =======================================================
    logic [SEL_W-1:0] fast_sel;

    // R02 fastest available source wins
    always_comb
    begin
        if (i_src_avail[SRC_PLL])
            fast_sel = SRC_PLL;
        else if (i_src_avail[SRC_DOUBLER])
            fast_sel = SRC_DOUBLER;
        else if (i_src_avail[SRC_MAIN_OSC])
            fast_sel = SRC_MAIN_OSC;
        else if (i_src_avail[SRC_HF_XTAL])
            fast_sel = SRC_HF_XTAL;
        else if (i_src_avail[SRC_ROUTE])
            fast_sel = SRC_ROUTE;
        else if (i_src_avail[SRC_LOW_OSC])
            fast_sel = SRC_LOW_OSC;
        else
            fast_sel = SRC_WATCH;
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_sys_src <= SRC_MAIN_OSC;
        else
            o_sys_src <= fast_sel;
    end

    // =======================================================
    // Bus and CPU clock
    // =======================================================
    logic bus_clk;
    logic bus_tick;

    // R03 dedicated bus divider on the system source
    clk_divider u_bus_div
    (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_src     ({8{src_s[o_sys_src]}}),
        .i_sel     (SEL_RST),
        .i_ratio   (i_bus_ratio),
        .i_skew    (4'h0),
        .i_run     (clocks_run),
        .o_clk     (bus_clk),
        .o_tick    (bus_tick)
    );

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_bus_clk  <= 1'b0;
            o_bus_tick <= 1'b0;
            o_cpu_tick <= 1'b0;
        end
        else
        begin
            o_bus_clk  <= bus_clk;
            o_bus_tick <= bus_tick;
            // R03 CPU ticks with the bus, gated by its enable
            o_cpu_tick <= bus_tick & o_subsys_en[SUB_CPU];
        end
    end

    // =======================================================
    // Digital and analog dividers
    // =======================================================
    logic [NUM_DIG-1:0] dig_clk;
    logic [NUM_DIG-1:0] dig_tick;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_DIG; gi++)
        begin : g_dig
            logic route_in;
            // R08 chain from the neighbour output, R09 own route
            assign route_in = i_dig_chain[gi] ?
                              dig_clk[(gi + NUM_DIG - 1) % NUM_DIG] :
                              route_s[gi];
            // R04 eight independent dividers, R01 all sources
            clk_divider u_div
            (
                .i_sys_clk (i_sys_clk),
                .i_reset_n (i_reset_n),
                .i_src     ({route_in, src_s}),
                .i_sel     (i_dig_sel[gi*3 +: 3]),
                .i_ratio   (i_dig_ratio[gi*16 +: 16]),
                .i_skew    (4'h0),
                .i_run     (clocks_run),
                .o_clk     (dig_clk[gi]),
                .o_tick    (dig_tick[gi])
            );
        end
        for (gi = 0; gi < NUM_ANA; gi++)
        begin : g_ana
            // R05 analog dividers carry skew control
            clk_divider u_div
            (
                .i_sys_clk (i_sys_clk),
                .i_reset_n (i_reset_n),
                .i_src     ({route_s[0], src_s}),
                .i_sel     (i_ana_sel[gi*3 +: 3]),
                .i_ratio   (i_ana_ratio[gi*16 +: 16]),
                .i_skew    (i_ana_skew[gi*4 +: 4]),
                .i_run     (clocks_run),
                .o_clk     (o_ana_clk[gi]),
                .o_tick    (o_ana_tick[gi])
            );
        end
    endgenerate

    assign o_dig_clk  = dig_clk;
    assign o_dig_tick = dig_tick;

    // =======================================================
    // Watch crystal: sleep timer and one-second tick
    // =======================================================
    logic        watch_prev_q;
    logic        watch_edge;
    logic [14:0] sec_cnt_q;

    assign watch_edge = src_s[SRC_WATCH] & ~watch_prev_q;

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            watch_prev_q <= 1'b0;
        else
            watch_prev_q <= src_s[SRC_WATCH];
    end

    // R11 one second of watch crystal edges
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            sec_cnt_q    <= '0;
            o_rtc_second <= 1'b0;
            o_sleep_tick <= 1'b0;
        end
        else
        begin
            o_sleep_tick <= watch_edge && o_slow_clk_en;
            o_rtc_second <= 1'b0;
            if (watch_edge && o_slow_clk_en)
            begin
                if (sec_cnt_q == WATCH_PER_S)
                begin
                    sec_cnt_q    <= '0;
                    o_rtc_second <= 1'b1;
                end
                else
                    sec_cnt_q <= sec_cnt_q + 15'h0001;
            end
        end
    end

    // =======================================================
    // Oscillator power setting and USB source
    // =======================================================
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_watch_low_power <= 1'b0;
            o_usb_use_doubler <= 1'b0;
        end
        else
        begin
            // R12 two watch oscillator power settings
            o_watch_low_power <= i_watch_low_power;
            // R13 route 48 MHz or doubler; R14 domain lives outside
            o_usb_use_doubler <= i_usb_use_doubler;
        end
    end

    // =======================================================
    // Checks
    // =======================================================
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);

    sequence in_sleep_s;
        mode_q == PM_SLEEP && !wake_any;
    endsequence

    sequence wake_s_seq;
        (mode_q == PM_SLEEP || mode_q == PM_HIBERNATE) && wake_any;
    endsequence

    wake_to_active_a: assert property (wake_s_seq ##1 1'b1
                                   |-> mode_q == PM_ACTIVE) // R22
        else $error("wake did not return to active");
    wake_cpu_on_a: assert property (wake_s_seq |-> ##2 o_subsys_en[SUB_CPU]) // R22
        else $error("CPU not enabled after wake");
    sleep_stays_a: assert property (in_sleep_s |=> mode_q == PM_SLEEP) // R19
        else $error("sleep left without a wake event");
    hib_pin_only_a: assert property (mode_q == PM_HIBERNATE
                                   && !wake_s[WAKE_PIN] |=> mode_q == PM_HIBERNATE) // R20
        else $error("hibernate left without pin wake");
    sleep_all_off_a: assert property (mode_q == PM_SLEEP |=> o_subsys_en == '0
                                   && o_slow_clk_en) // R18
        else $error("subsystem enabled during sleep");
    hib_clocks_off_a: assert property (mode_q == PM_HIBERNATE
                                   |=> !o_slow_clk_en) // R20
        else $error("slow clock kept in hibernate");
    active_tmpl_a: assert property (mode_q == PM_ACTIVE && !cpu_force_q
                                   |=> o_subsys_en == $past(i_active_tmpl)) // R16
        else $error("active template not applied");
    alt_tmpl_a: assert property (mode_q == PM_ALTERNATE && !cpu_force_q
                                   |=> o_subsys_en == $past(i_alt_tmpl)) // R17
        else $error("alternate template not applied");
    reg_no_return_a: assert property ($fell(o_core_reg_en[0])
                                   |=> !o_core_reg_en[0]) // R21
        else $error("regulator re-enabled without reset");
    fastest_src_a: assert property (i_src_avail[SRC_PLL]
                                   |=> o_sys_src == SRC_PLL) // R02
        else $error("system clock not on fastest source");
endmodule
`default_nettype wire
